/* File: hw/tweh_ctrl.sv */
// Host controller driving a two-wire serial memory over open-drain clock and data pins.
// Assumes an AHB-Lite master with single word transfers and external pull-ups on the pins.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - Data falls while clock high to open every command except recovery, which clocks first.
// - Data rises while clock high to stop; device then idles.
// - Data changes only during clock low except start and stop.
// - Recovery clocks up to nine cycles watching data high, then start.
// - Each start is followed by an address byte with type pattern 1010.
// - Byte write sends address, word address, one data byte, then stop.
// - Page write sends up to thirty-two data bytes before the stop.
// - Current read takes one byte, withholds acknowledge, then stops.
// - Random read uses a dummy write, repeated start, then reads.
// - Sequential read acknowledges each byte but the last, then stops.
module tweh_ctrl (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic write_protect_o
);
    typedef struct packed {
        tweh_pkg::tweh_state_t st;
        logic wr_pend;
        logic [11:0] wr_ofs;
        logic [31:0] rdata;
        logic [2:0] chip;
        logic wp;
        logic [15:0] waddr;
        logic [3:0][7:0] wbuf;
        logic [5:0] count;
        logic [2:0] cmd;
        logic busy;
        logic nack;
        logic [7:0] rbyte;
        logic [15:0] tick;
        logic scl_low;
        logic sda_low;
        logic [8:0] shreg;
        logic [3:0] bitn;
        logic [2:0] phase;
        logic [5:0] done_n;
        logic [3:0] rec_n;
        logic s1_scl;
        logic s2_scl;
        logic s1_sda;
        logic s2_sda;
        logic [7:0] rd_last;
    } tweh_regs_t;
    tweh_regs_t r;
    tweh_regs_t next_r;
    logic half;
    logic [7:0] data_byte;
    logic [31:0] rd_mux;

    assign half = (r.tick == 16'h0000);
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // Open-drain: enable is low when the pin is pulled low
    assign scl_oe_o = ~r.scl_low;
    assign sda_oe_o = ~r.sda_low;
    assign hrdata_o = r.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign write_protect_o = r.wp;
    assign data_byte = r.wbuf[r.done_n[1:0]];

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (haddr_i[11:0] == tweh_pkg::OFS_STATUS)
        begin
            rd_mux = {29'h0000_0000, r.s2_sda, r.nack, r.busy};
        end
        else if (haddr_i[11:0] == tweh_pkg::OFS_RDATA)
        begin
            rd_mux = {24'h00_0000, r.rd_last};
        end
        else if (haddr_i[11:0] == tweh_pkg::OFS_CONF)
        begin
            rd_mux = {28'h000_0000, r.wp, r.chip};
        end
        else if (haddr_i[11:0] == tweh_pkg::OFS_ADDR)
        begin
            rd_mux = {16'h0000, r.waddr};
        end
        else if (haddr_i[11:0] == tweh_pkg::OFS_WDATA)
        begin
            rd_mux = {r.wbuf[3], r.wbuf[2], r.wbuf[1], r.wbuf[0]};
        end
    end

    always_comb
    begin
        next_r = r;
        next_r.s1_scl = scl_i;
        next_r.s2_scl = r.s1_scl;
        next_r.s1_sda = sda_i;
        next_r.s2_sda = r.s1_sda;
        next_r.tick = half ? tweh_pkg::HALF_LOAD : r.tick - 16'h0001;
        // Bus slave: address phase captured, write data applied next cycle
        next_r.wr_pend = 1'b0;
        if (hsel_i && hready_i && htrans_i == tweh_pkg::HTRANS_NONSEQ)
        begin
            next_r.wr_pend = hwrite_i;
            next_r.wr_ofs = haddr_i[11:0];
            if (!hwrite_i)
            begin
                next_r.rdata = rd_mux;
            end
        end
        if (r.wr_pend)
        begin
            if (r.wr_ofs == tweh_pkg::OFS_CONF)
            begin
                next_r.chip = hwdata_i[2:0];
                next_r.wp = hwdata_i[3];
            end
            else if (r.wr_ofs == tweh_pkg::OFS_ADDR)
            begin
                next_r.waddr = hwdata_i[15:0];
            end
            else if (r.wr_ofs == tweh_pkg::OFS_WDATA)
            begin
                next_r.wbuf[0] = hwdata_i[7:0];
                next_r.wbuf[1] = hwdata_i[15:8];
                next_r.wbuf[2] = hwdata_i[23:16];
                next_r.wbuf[3] = hwdata_i[31:24];
            end
            else if (r.wr_ofs == tweh_pkg::OFS_CTRL && !r.busy)
            begin
                next_r.cmd = hwdata_i[2:0];
                next_r.count = (hwdata_i[13:8] == 6'h00 || hwdata_i[13:8] > tweh_pkg::MAX_BYTES)
                    ? 6'h01 : hwdata_i[13:8];
                next_r.busy = 1'b1;
                next_r.nack = 1'b0;
                next_r.done_n = 6'h00;
                next_r.rec_n = 4'h0;
                next_r.tick = tweh_pkg::HALF_LOAD;
                next_r.st = (hwdata_i[2:0] == tweh_pkg::CMD_RECOVER)
                    ? tweh_pkg::TWEH_REC_LO : tweh_pkg::TWEH_START;
            end
        end
        if (half)
        begin
            case (r.st)
                tweh_pkg::TWEH_START:
                begin
                    // Phase 0 release both, phase 1 drop data, then clock low
                    if (!r.sda_low && r.s2_scl)
                    begin
                        next_r.sda_low = 1'b1;
                        next_r.phase = 3'h0;
                        next_r.shreg = {tweh_pkg::DEV_TYPE, r.chip,
                            r.cmd == tweh_pkg::CMD_READ_CUR, 1'b1};
                        next_r.bitn = 4'h0;
                        next_r.st = tweh_pkg::TWEH_BIT_LO;
                    end
                    else
                    begin
                        next_r.scl_low = 1'b0;
                        next_r.sda_low = 1'b0;
                    end
                end
                tweh_pkg::TWEH_RSTART:
                begin
                    next_r.sda_low = 1'b0;
                    next_r.scl_low = 1'b0;
                    next_r.cmd = tweh_pkg::CMD_READ_CUR;
                    next_r.st = tweh_pkg::TWEH_START;
                end
                tweh_pkg::TWEH_BIT_LO:
                begin
                    // Clock low, then data set up while low
                    next_r.scl_low = 1'b1;
                    next_r.sda_low = r.scl_low ? ~r.shreg[8] : r.sda_low;
                    if (r.scl_low)
                    begin
                        next_r.st = tweh_pkg::TWEH_BIT_HI;
                    end
                end
                tweh_pkg::TWEH_BIT_HI:
                begin
                    next_r.scl_low = 1'b0;
                    if (r.s2_scl)
                    begin
                        next_r.shreg = {r.shreg[7:0], r.s2_sda};
                        next_r.bitn = r.bitn + 4'h1;
                        next_r.st = (r.bitn == tweh_pkg::BITS_PER_WORD)
                            ? tweh_pkg::TWEH_NEXT : tweh_pkg::TWEH_BIT_LO;
                    end
                end
                tweh_pkg::TWEH_NEXT:
                begin
                    next_r.scl_low = 1'b1;
                    next_r.bitn = 4'h0;
                    next_r.st = tweh_pkg::TWEH_BIT_LO;
                    if (r.phase == 3'h5)
                    begin
                        // Read byte received: shreg[8:1] holds it
                        next_r.rd_last = r.shreg[8:1];
                        next_r.done_n = r.done_n + 6'h01;
                        if (r.done_n + 6'h01 >= r.count)
                        begin
                            next_r.st = tweh_pkg::TWEH_STOP_LO;
                        end
                        else
                        begin
                            // Withhold the acknowledge on the last byte only
                            next_r.shreg = (r.done_n + 6'h02 >= r.count)
                                ? 9'h1FF : 9'h1FE;
                        end
                    end
                    else if (r.shreg[0])
                    begin
                        next_r.nack = 1'b1;
                        next_r.st = tweh_pkg::TWEH_STOP_LO;
                    end
                    else if (r.phase == 3'h0)
                    begin
                        if (r.cmd == tweh_pkg::CMD_POLL)
                        begin
                            next_r.st = tweh_pkg::TWEH_STOP_LO;
                        end
                        else if (r.cmd == tweh_pkg::CMD_READ_CUR)
                        begin
                            next_r.phase = 3'h5;
                            next_r.shreg = (r.count == 6'h01) ? 9'h1FF : 9'h1FE;
                        end
                        else
                        begin
                            next_r.phase = 3'h1;
                            next_r.shreg = {r.waddr[15:8], 1'b1};
                        end
                    end
                    else if (r.phase == 3'h1)
                    begin
                        next_r.phase = 3'h2;
                        next_r.shreg = {r.waddr[7:0], 1'b1};
                    end
                    else if (r.cmd == tweh_pkg::CMD_READ_RND)
                    begin
                        next_r.st = tweh_pkg::TWEH_RSTART;
                    end
                    else if (r.cmd == tweh_pkg::CMD_SETADDR || r.done_n == r.count)
                    begin
                        next_r.st = tweh_pkg::TWEH_STOP_LO;
                    end
                    else
                    begin
                        // page wrap is done by the device; host just streams
                        next_r.phase = 3'h3;
                        next_r.shreg = {data_byte, 1'b1};
                        next_r.done_n = r.done_n + 6'h01;
                    end
                end
                tweh_pkg::TWEH_STOP_LO:
                begin
                    next_r.scl_low = 1'b1;
                    next_r.sda_low = r.scl_low;
                    if (r.scl_low)
                    begin
                        next_r.st = tweh_pkg::TWEH_STOP_HI;
                    end
                end
                tweh_pkg::TWEH_STOP_HI:
                begin
                    next_r.scl_low = 1'b0;
                    if (r.s2_scl)
                    begin
                        next_r.st = tweh_pkg::TWEH_STOP_END;
                    end
                end
                tweh_pkg::TWEH_STOP_END:
                begin
                    next_r.sda_low = 1'b0;
                    next_r.busy = 1'b0;
                    next_r.st = tweh_pkg::TWEH_IDLE;
                end
                tweh_pkg::TWEH_REC_LO:
                begin
                    next_r.sda_low = 1'b0;
                    next_r.scl_low = 1'b1;
                    next_r.st = tweh_pkg::TWEH_REC_HI;
                end
                tweh_pkg::TWEH_REC_HI:
                begin
                    next_r.scl_low = 1'b0;
                    if (r.s2_scl)
                    begin
                        next_r.rec_n = r.rec_n + 4'h1;
                        if (r.s2_sda || r.rec_n + 4'h1 >= tweh_pkg::RECOVER_CLOCKS)
                        begin
                            next_r.cmd = tweh_pkg::CMD_POLL;
                            next_r.st = tweh_pkg::TWEH_START;
                        end
                        else
                        begin
                            next_r.st = tweh_pkg::TWEH_REC_LO;
                        end
                    end
                end
                default:
                begin
                    next_r.scl_low = 1'b0;
                    next_r.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end
endmodule

/* File: hw/tweh_pkg.sv */
// Constants for the two-wire memory controller: register map, commands, timing.
// Assumes a 250 MHz system clock and an AHB-Lite software port.
package tweh_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned SCL_HALF_NS = 1250;
    localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] HALF_LOAD = 16'(SCL_HALF_CYC - 1);
    localparam logic [3:0] DEV_TYPE = 4'h0_00A;
    localparam logic [3:0] RECOVER_CLOCKS = 4'h0_009;
    localparam logic [3:0] BITS_PER_WORD = 4'h0_008;
    localparam logic [11:0] OFS_CTRL = 12'h0_000;
    localparam logic [11:0] OFS_ADDR = 12'h0_004;
    localparam logic [11:0] OFS_WDATA = 12'h0_008;
    localparam logic [11:0] OFS_STATUS = 12'h0_00C;
    localparam logic [11:0] OFS_RDATA = 12'h0_010;
    localparam logic [11:0] OFS_CONF = 12'h0_014;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_SETADDR = 3'h2;
    localparam logic [2:0] CMD_READ_CUR = 3'h3;
    localparam logic [2:0] CMD_READ_RND = 3'h4;
    localparam logic [2:0] CMD_POLL = 3'h5;
    localparam logic [2:0] CMD_RECOVER = 3'h6;
    localparam logic [5:0] MAX_BYTES = 6'h20;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [3:0] {
        TWEH_IDLE = 4'h0,
        TWEH_START = 4'h1,
        TWEH_BIT_LO = 4'h2,
        TWEH_BIT_HI = 4'h3,
        TWEH_NEXT = 4'h4,
        TWEH_STOP_LO = 4'h5,
        TWEH_STOP_HI = 4'h6,
        TWEH_STOP_END = 4'h7,
        TWEH_REC_LO = 4'h8,
        TWEH_REC_HI = 4'h9,
        TWEH_RSTART = 4'hA
    } tweh_state_t;
endpackage

/* File: bench/tweh_ctrl_props.sv */
// Checker for the two-wire memory controller: pin timing and bus answers.
// Bound to tweh_ctrl; sees only its ports.
`timescale 1ns/1ps
module tweh_ctrl_props (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic write_protect_o
);
    logic [15:0] hcnt;
    // Cycles since the clock pin last changed
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            hcnt <= 16'h0000;
        else if ($changed(scl_oe_o))
            hcnt <= 16'h0001;
        else if (hcnt != 16'hFFFF)
            hcnt <= hcnt + 16'h0001;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    a_start_clock_high: assert property (
        $fell(sda_oe_o) && scl_oe_o |=> scl_oe_o [*8]) else $error("start without clock high");
    a_stop_clock_high: assert property (
        $rose(sda_oe_o) && scl_oe_o |-> $past(scl_oe_o, 8)) else $error("stop too early");
    a_data_hold_high: assert property (
        $rose(scl_oe_o) |-> $stable(sda_oe_o) [*8]) else $error("data moved with clock high");
    a_half_period_min: assert property (
        $changed(scl_oe_o) |-> hcnt >= 16'h0130) else $error("clock phase too short");
    a_reset_lines_free: assert property (
        $rose(resetn_i) |-> scl_oe_o && sda_oe_o) else $error("pins driven after reset");
    a_open_drain_low: assert property (
        scl_o == 1'b0 && sda_o == 1'b0) else $error("pin drives high");
    a_protect_follows: assert property (
        hsel_i && hready_i && htrans_i == tweh_pkg::HTRANS_NONSEQ && hwrite_i
        && haddr_i[11:0] == tweh_pkg::OFS_CONF |=> ##1 write_protect_o == $past(hwdata_i[3]))
        else $error("protect level wrong");
    a_bus_answer_okay: assert property (
        hreadyout_o && !hresp_o) else $error("bus answer not ready okay");
endmodule
bind tweh_ctrl tweh_ctrl_props tweh_ctrl_props_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .write_protect_o(write_protect_o));

/* File: bench/tweh_eeprom_model.sv */
// Behavioural two-wire serial memory, larger 13-bit variant, as the far side.
// Assumes resolved clock and data wires with pull-ups; output low enables a drive low.
`timescale 1ns/1ps
module tweh_eeprom_model #(
    parameter logic [2:0] CHIP = 3'h5,
    parameter int WR_NS = 20000
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic wp_i,
    output logic sda_oe_o
);
    logic [7:0] mem [0:8191];
    logic [7:0] sr, tx;
    logic [12:0] ctr, wa;
    logic [12:0] pa [0:31];
    logic [7:0] pd [0:31];
    logic active, rd, busy;
    int cnt, ph, np;
    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'(i) ^ 8'h5A;
        sda_oe_o = 1'b1;
        active = 1'b0;
        busy = 1'b0;
        ctr = 13'h0000;
        np = 0;
    end
    always @(negedge sda_i)
    begin
        if (scl_i)
        begin
            active = 1'b1;
            cnt = -1;
            ph = 0;
            rd = 1'b0;
        end
    end
    always @(posedge sda_i)
    begin
        if (scl_i)
        begin
            if (np > 0 && !wp_i)
            begin
                for (int i = 0; i < np && i < 32; i++)
                    mem[pa[i]] = pd[i];
                ctr = wa;
                busy = 1'b1;
                busy <= #(WR_NS) 1'b0;
            end
            np = 0;
            active = 1'b0;
            sda_oe_o = 1'b1;
        end
    end
    always @(posedge scl_i)
    begin
        if (active && cnt >= 0 && cnt < 8)
            sr = {sr[6:0], sda_i};
        else if (active && cnt == 8 && rd && sda_i)
            active = 1'b0;
    end
    always @(negedge scl_i)
    begin
        if (active && cnt == 7)
        begin
            cnt = 8;
            if (rd)
                sda_oe_o = 1'b1;
            else if (ph == 0 && (sr[7:4] != 4'hA || sr[3:1] != CHIP || busy))
                active = 1'b0;
            else
            begin
                sda_oe_o = 1'b0;
                case (ph)
                    0: rd = sr[0];
                    1: wa[12:8] = sr[4:0];
                    2:
                    begin
                        wa[7:0] = sr;
                        ctr = wa;
                    end
                    default:
                    begin
                        pa[np % 32] = wa;
                        pd[np % 32] = sr;
                        np++;
                        wa[4:0] = wa[4:0] + 5'h01;
                    end
                endcase
                ph = (ph < 3) ? ph + 1 : 3;
            end
        end
        else if (active && cnt == 8)
        begin
            cnt = 0;
            if (rd)
            begin
                tx = mem[ctr];
                ctr = ctr + 13'h0001;
            end
            sda_oe_o = rd ? tx[7] : 1'b1;
        end
        else if (active)
        begin
            cnt++;
            if (rd)
                sda_oe_o = tx[7 - cnt];
        end
    end
endmodule

/* File: bench/tweh_ctrl_tb_top.sv */
// Testbench for the two-wire memory controller: register tasks over AHB-Lite.
// Assumes the memory model on pulled-up wires; model write time shortened.
`timescale 1ns/1ps
module tweh_ctrl_tb_top;
    logic clock_i, resetn_i, hsel_i, hwrite_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rv;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic hreadyout_o, hresp_o, scl_o, scl_oe_o, sda_o, sda_oe_o, write_protect_o, dev_oe;
    logic scl_w, sda_w;
    int n_mismatch, tests_run;
    assign scl_w = scl_oe_o | scl_o;
    assign sda_w = (sda_oe_o | sda_o) & dev_oe;
    tweh_ctrl tweh_ctrl_i (.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .write_protect_o(write_protect_o));
    tweh_eeprom_model tweh_eeprom_model_i (.scl_i(scl_w), .sda_i(sda_w),
        .wp_i(write_protect_o), .sda_oe_o(dev_oe));
    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic print_verdict();
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1)
        begin
            k++;
            if (k > 100)
            begin
                n_mismatch++;
                print_verdict();
            end
            @(posedge clock_i);
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= {20'h0_0000, a};
        hwrite_i <= w;
        htrans_i <= tweh_pkg::HTRANS_NONSEQ;
        wait_ready();
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        wait_ready();
        rv = hrdata_o;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        check(rv, exp);
    endtask
    // Start a command and poll until the controller reports idle
    task automatic run_cmd(input logic [31:0] c);
        int k;
        k = 0;
        ahb(1'b1, tweh_pkg::OFS_CTRL, c);
        do
        begin
            ahb(1'b0, tweh_pkg::OFS_STATUS, 32'h0000_0000);
            k++;
        end while (rv[0] !== 1'b0 && k < 40000);
        if (k >= 40000)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    initial
    begin
        resetn_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0000_0000;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0000_0000;
        n_mismatch = 0;
        tests_run = 0;
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        // Let the pin synchronisers see the pulled-up lines
        repeat (2) @(posedge clock_i);
        rd_chk(tweh_pkg::OFS_STATUS, 32'h0000_0004);
        rd_chk(tweh_pkg::OFS_RDATA, 32'h0000_0000);
        rd_chk(12'h0FC, 32'h0000_0000);
        ahb(1'b1, tweh_pkg::OFS_CONF, 32'h0000_000D);
        @(posedge clock_i);
        check({31'h0000_0000, write_protect_o}, 32'h0000_0001);
        ahb(1'b1, tweh_pkg::OFS_CONF, 32'h0000_0005);
        ahb(1'b1, tweh_pkg::OFS_ADDR, 32'h0000_101F);
        ahb(1'b1, tweh_pkg::OFS_WDATA, 32'hC3A5_7E11);
        run_cmd(32'h0000_0201);
        rd_chk(tweh_pkg::OFS_STATUS, 32'h0000_0004);
        check({24'h00_0000, tweh_eeprom_model_i.mem[13'h101F]}, 32'h0000_0011);
        check({24'h00_0000, tweh_eeprom_model_i.mem[13'h1000]}, 32'h0000_007E);
        check({24'h00_0000, tweh_eeprom_model_i.mem[13'h1020]}, 32'h0000_007A);
        run_cmd(32'h0000_0106);
        rd_chk(tweh_pkg::OFS_STATUS, 32'h0000_0004);
        ahb(1'b1, tweh_pkg::OFS_ADDR, 32'h0000_1000);
        run_cmd(32'h0000_0104);
        rd_chk(tweh_pkg::OFS_RDATA, 32'h0000_007E);
        ahb(1'b1, tweh_pkg::OFS_CONF, 32'h0000_0002);
        run_cmd(32'h0000_0103);
        rd_chk(tweh_pkg::OFS_STATUS, 32'h0000_0006);
        print_verdict();
    end
endmodule
